// ### hdl/ccl_pkg.sv
// Package: register map, field layout and constants of the comparator control
package ccl_pkg;
    // -------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [3:0] IDX_STATUS = 4'h3;
    localparam logic [3:0] IDX_CTRL = 4'h7;
    localparam logic [3:0] IDX_PINDIR = 4'h8;
    localparam logic [3:0] IDX_TMROPT = 4'h9;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 6;

    // -------------------------------------------------------------------
    // Reset values and field positions
    // -------------------------------------------------------------------
    localparam logic [7:0] CTRL_POR = 8'hFF;
    localparam logic [3:0] PINDIR_RST = 4'hF;
    localparam logic [1:0] TMROPT_RST = 2'h3;
    localparam int STAT_PIN_WAKE = 7;
    localparam int STAT_CMP_WAKE = 6;
    localparam int PINDIR_SHARED = 2;
    localparam int CTRL_WR_MSB = 6;

    // Instruction cycle is this many core clocks
    localparam int INSTR_DIV_DEF = 4;

    // Comparator control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic compare_result;
        logic result_pin_enable_n;
        logic output_invert_n;
        logic cmp_timer_clk_select;
        logic compare_power_on;
        logic neg_input_select;
        logic pos_input_select;
        logic change_wake_enable_n;
    } ccl_ctrl_t;

    // Timer option bits kept beside the comparator
    typedef struct packed {
        logic timer_clk_select;
        logic count_edge_select;
    } ccl_tmropt_t;
endpackage

// ### hdl/ccl_comparator_control.sv
// Comparator control logic: APB registers, pin steering, timer source, wake
`timescale 1ns/10ps
module ccl_comparator_control #(
    parameter int INSTR_DIV = ccl_pkg::INSTR_DIV_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compare_raw,
    input wire logic ext_count_pin,
    input wire logic sleep_mode,
    input wire logic other_reset,
    input wire logic reset_cause_wake,
    input wire logic pin_change_wake,
    output logic compare_power_on,
    output logic neg_input_select,
    output logic pos_input_select,
    output logic shared_output_pin_o,
    output logic shared_output_pin_oe,
    output logic timer_tick,
    output logic compare_wake
);
    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    ccl_pkg::ccl_ctrl_t ctrl_reg;
    ccl_pkg::ccl_tmropt_t tmropt_reg;
    logic [3:0] pindir_reg;
    logic pin_wake_reg;
    logic cmp_wake_reg;
    logic cmp_meta_reg;
    logic cmp_sync_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic latched_reg;
    logic armed_reg;
    logic src_prev_reg;
    logic [7:0] div_reg;
    logic instr_en;
    logic result;
    logic on;
    logic feedback;
    logic count_src;
    logic wake_event;
    logic setup;
    logic access;
    logic [3:0] idx;
    logic mapped;
    logic [7:0] rdata_next;

    // Divider counter is eight bits wide
    if (INSTR_DIV < 2 || INSTR_DIV > 256) begin : g_div_check
        $error("INSTR_DIV must lie in 2..256");
    end

    // -------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------
    // two-stage result sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            cmp_meta_reg <= compare_raw;
            cmp_sync_reg <= cmp_meta_reg;
            pin_meta_reg <= ext_count_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // -------------------------------------------------------------------
    // Effective control decode
    // -------------------------------------------------------------------
    // power bit gates every other control
    assign on = ctrl_reg.compare_power_on;
    assign result = on & (cmp_sync_reg ^ ~ctrl_reg.output_invert_n);
    // driven pin loops into count input
    assign feedback = on & ctrl_reg.cmp_timer_clk_select
        & ~ctrl_reg.result_pin_enable_n;

    // Timer source select; off means comparator settings are void
    always_comb begin
        count_src = feedback ? result : pin_sync_reg;
        // count pin when off, or when select and pin disable both set
        // powered off, the count pin whatever the timer select
        if (on && !(ctrl_reg.cmp_timer_clk_select
                && ctrl_reg.result_pin_enable_n)) begin
            count_src = result;
        end
    end

    // -------------------------------------------------------------------
    // Instruction cycle divider
    // -------------------------------------------------------------------
    // Enable pulse instead of a derived clock keeps one domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 8'h00;
        end else if (div_reg == 8'(INSTR_DIV - 1)) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign instr_en = (div_reg == 8'(INSTR_DIV - 1));

    // -------------------------------------------------------------------
    // Timer tick generation
    // -------------------------------------------------------------------
    // Edge of selected source, edge choice from the option bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_reg <= 1'b0;
            timer_tick <= 1'b0;
        end else begin
            src_prev_reg <= count_src;
            // instruction clock when select is zero
            if (!tmropt_reg.timer_clk_select) begin
                timer_tick <= instr_en;
            end else if (tmropt_reg.count_edge_select) begin
                timer_tick <= src_prev_reg & ~count_src;
            end else begin
                timer_tick <= ~src_prev_reg & count_src;
            end
        end
    end

    // -------------------------------------------------------------------
    // Shared output pin and analog controls
    // -------------------------------------------------------------------
    // Registered so the pin never glitches on decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_output_pin_o <= 1'b0;
            shared_output_pin_oe <= 1'b0;
            compare_power_on <= 1'b0;
            neg_input_select <= 1'b1;
            pos_input_select <= 1'b1;
        end else begin
            shared_output_pin_o <= result;
            if (on && !ctrl_reg.result_pin_enable_n) begin
                shared_output_pin_oe <= 1'b1;
            end else if (tmropt_reg.timer_clk_select) begin
                shared_output_pin_oe <= 1'b0;
            end else begin
                shared_output_pin_oe <= ~pindir_reg[ccl_pkg::PINDIR_SHARED];
            end
            // held down while a reset is active
            // sleep does not power it down
            compare_power_on <= on & ~other_reset;
            neg_input_select <= ctrl_reg.neg_input_select | ~on;
            pos_input_select <= ctrl_reg.pos_input_select | ~on;
        end
    end

    // -------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign idx = paddr[ccl_pkg::ADDR_LSB +: 4];
    assign mapped = (paddr[31:ccl_pkg::ADDR_W] == '0)
        && (paddr[ccl_pkg::ADDR_LSB-1:0] == 2'h0)
        && (idx == ccl_pkg::IDX_STATUS || idx == ccl_pkg::IDX_CTRL
            || idx == ccl_pkg::IDX_PINDIR || idx == ccl_pkg::IDX_TMROPT);

    // Read mux; unused status bits read zero
    always_comb begin
        rdata_next = 8'h00;
        unique case (idx)
            ccl_pkg::IDX_STATUS: begin
                // wake flags in the top two bits
                rdata_next[ccl_pkg::STAT_PIN_WAKE] = pin_wake_reg;
                rdata_next[ccl_pkg::STAT_CMP_WAKE] = cmp_wake_reg;
            end
            ccl_pkg::IDX_CTRL: begin
                // live result in the top bit
                rdata_next = {result, ctrl_reg[6:0]};
            end
            ccl_pkg::IDX_PINDIR: rdata_next = {4'h0, pindir_reg};
            ccl_pkg::IDX_TMROPT: rdata_next = {6'h00, tmropt_reg};
            default: rdata_next = 8'h00;
        endcase
        if (!mapped) begin
            rdata_next = 8'h00;
        end
    end

    // Answer prepared in setup: access phase always completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rdata_next};
            end
        end
    end

    // -------------------------------------------------------------------
    // Control registers
    // -------------------------------------------------------------------
    // only power-on reset loads ones into the control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ccl_pkg::CTRL_POR;
            pindir_reg <= ccl_pkg::PINDIR_RST;
            tmropt_reg <= ccl_pkg::TMROPT_RST;
        end else if (other_reset) begin
            // Direction and option return to defaults, control kept
            pindir_reg <= ccl_pkg::PINDIR_RST;
            tmropt_reg <= ccl_pkg::TMROPT_RST;
        end else if (access && pwrite && !pslverr) begin
            if (idx == ccl_pkg::IDX_CTRL) begin
                ctrl_reg[ccl_pkg::CTRL_WR_MSB:0] <=
                    pwdata[ccl_pkg::CTRL_WR_MSB:0];
            end
            if (idx == ccl_pkg::IDX_PINDIR) begin
                pindir_reg <= pwdata[3:0];
            end
            if (idx == ccl_pkg::IDX_TMROPT) begin
                tmropt_reg <= pwdata[1:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // Wake detection
    // -------------------------------------------------------------------
    // reading the control register latches result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (other_reset) begin
            armed_reg <= 1'b0;
        end else if (access && !pwrite && !pslverr
                && idx == ccl_pkg::IDX_CTRL) begin
            latched_reg <= prdata[7];
            armed_reg <= 1'b1;
        end
    end

    // change in sleep after a read
    assign wake_event = ~ctrl_reg.change_wake_enable_n & on & armed_reg
        & sleep_mode & (result != latched_reg);

    // set wins over a clear in the same cycle
    // a wake-caused reset keeps the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_wake_reg <= 1'b0;
            pin_wake_reg <= 1'b0;
            compare_wake <= 1'b0;
        end else begin
            // One pulse per wake, not for as long as the change persists
            compare_wake <= wake_event & ~cmp_wake_reg;
            if (wake_event) begin
                cmp_wake_reg <= 1'b1;
            end else if (other_reset && !reset_cause_wake) begin
                cmp_wake_reg <= 1'b0;
            end else if (access && pwrite && idx == ccl_pkg::IDX_STATUS
                    && !pslverr && !pwdata[ccl_pkg::STAT_CMP_WAKE]) begin
                cmp_wake_reg <= 1'b0;
            end
            if (pin_change_wake) begin
                pin_wake_reg <= 1'b1;
            end else if (other_reset && !reset_cause_wake) begin
                pin_wake_reg <= 1'b0;
            end else if (access && pwrite && idx == ccl_pkg::IDX_STATUS
                    && !pslverr && !pwdata[ccl_pkg::STAT_PIN_WAKE]) begin
                pin_wake_reg <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_result_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && mapped && idx == ccl_pkg::IDX_CTRL
        |=> prdata[7] == $past(result))
        else $error("result bit read wrong");
    a_result_ro: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ctrl_reg.compare_result == 1'b1)
        else $error("result bit was written");
    a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        on && !ctrl_reg.result_pin_enable_n
        |=> shared_output_pin_oe && shared_output_pin_o == $past(result))
        else $error("pin not driven with result");
    a_pin_priority: assert property (@(posedge pclk) disable iff (!presetn)
        on && ctrl_reg.result_pin_enable_n && tmropt_reg.timer_clk_select
        |=> !shared_output_pin_oe)
        else $error("pin driven while disabled");
    a_polarity: assert property (@(posedge pclk) disable iff (!presetn)
        on |=> shared_output_pin_o
            == ($past(cmp_sync_reg) ^ !$past(ctrl_reg.output_invert_n)))
        else $error("polarity wrong");
    a_timer_instr: assert property (@(posedge pclk) disable iff (!presetn)
        !tmropt_reg.timer_clk_select ##1 !tmropt_reg.timer_clk_select
        |-> timer_tick == $past(instr_en))
        else $error("instruction tick wrong");
    a_power_reset: assert property (@(posedge pclk) disable iff (!presetn)
        other_reset |=> !compare_power_on)
        else $error("powered during reset");
    a_ctrl_keep: assert property (@(posedge pclk) disable iff (!presetn)
        other_reset |=> $stable(ctrl_reg))
        else $error("control changed by reset");
    a_wake_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cmp_wake_reg) |-> $past(sleep_mode) && $past(armed_reg)
        && !$past(ctrl_reg.change_wake_enable_n))
        else $error("wake flag without cause");
    a_wake_clear: assert property (@(posedge pclk) disable iff (!presetn)
        other_reset && !reset_cause_wake && !wake_event |=> !cmp_wake_reg)
        else $error("wake flag not cleared");
endmodule // ccl_comparator_control

// ### bench/ccl_analog_model.sv
// Behavioural model of the analog comparator core with input steering
`timescale 1ns/10ps
module ccl_analog_model #(
    parameter int SETTLE = 3
) (
    input wire logic pclk,
    input wire logic compare_power_on,
    input wire logic neg_input_select,
    input wire logic pos_input_select,
    input wire logic [7:0] pos_pin_level,
    input wire logic [7:0] neg_pin_level,
    input wire logic [7:0] vref_level,
    output logic compare_raw
);
    // -------------------------------------------------------------------
    // Input steering and comparison
    // -------------------------------------------------------------------
    logic [7:0] vin_p;
    logic [7:0] vin_n;
    logic [2:0] mode_now;
    logic [2:0] mode_last = 3'b000;
    int settle_cnt = 0;

    assign vin_p = pos_input_select ? pos_pin_level : neg_pin_level;
    assign vin_n = neg_input_select ? neg_pin_level : vref_level;
    assign mode_now = {compare_power_on, neg_input_select, pos_input_select};

    initial compare_raw = 1'b0;

    // power, compare and settling
    // Unpowered or settling output churns so no stale level can pass
    always @(posedge pclk) begin
        mode_last <= mode_now;
        if (mode_last != mode_now) begin
            settle_cnt <= SETTLE;
        end else if (settle_cnt > 0) begin
            settle_cnt <= settle_cnt - 1;
        end
        if (!compare_power_on || settle_cnt > 0) begin
            compare_raw <= (compare_raw !== 1'b1);
        end else begin
            compare_raw <= (vin_p > vin_n);
        end
    end
endmodule // ccl_analog_model

// ### bench/test_ccl_comparator_control.sv
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module test_ccl_comparator_control;
    // -------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------
    localparam int DIV = 5;
    logic pclk = 1'b0;
    logic presetn;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic compare_raw;
    logic ext_count_pin;
    logic ext_drv = 1'b0;
    logic sleep_mode = 1'b0;
    logic other_reset = 1'b0;
    logic reset_cause_wake = 1'b0;
    logic pin_change_wake = 1'b0;
    logic compare_power_on;
    logic neg_input_select;
    logic pos_input_select;
    logic pin_o;
    logic pin_oe;
    logic timer_tick;
    logic compare_wake;
    logic [7:0] pos_lv = 8'h40;
    logic [7:0] neg_lv = 8'h80;
    logic [31:0] rdat = 32'h0;
    logic rerr = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    int ticks = 0;
    int wakes = 0;
    logic [7:0] tc_ctrl [5] = '{8'h6F, 8'h7F, 8'h67, 8'h3F, 8'h6F};
    logic [4:0] tc_cmp = 5'b01001;
    int tc_exp [5] = '{3, 3, 3, 3, 0};

    always #2 pclk = ~pclk;
    // Shared pin: the block wins while it drives, else the bench
    assign ext_count_pin = pin_oe ? pin_o : ext_drv;

    // Pulse counters, sampled like a flop
    always @(posedge pclk) begin
        if (timer_tick === 1'b1) ticks++;
        if (compare_wake === 1'b1) wakes++;
    end

    ccl_comparator_control #(.INSTR_DIV(DIV)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .compare_raw(compare_raw),
        .ext_count_pin(ext_count_pin), .sleep_mode(sleep_mode),
        .other_reset(other_reset), .reset_cause_wake(reset_cause_wake),
        .pin_change_wake(pin_change_wake),
        .compare_power_on(compare_power_on),
        .neg_input_select(neg_input_select),
        .pos_input_select(pos_input_select),
        .shared_output_pin_o(pin_o), .shared_output_pin_oe(pin_oe),
        .timer_tick(timer_tick), .compare_wake(compare_wake));

    ccl_analog_model #(.SETTLE(3)) analog (
        .pclk(pclk), .compare_power_on(compare_power_on),
        .neg_input_select(neg_input_select),
        .pos_input_select(pos_input_select), .pos_pin_level(pos_lv),
        .neg_pin_level(neg_lv), .vref_level(8'h80),
        .compare_raw(compare_raw));

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    function automatic logic exp_res(input logic [7:0] a, input logic [7:0] b);
        return a > b;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            wrap_up();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel at once
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdat, exp);
    endtask

    // Counts read off the edge so the counter process has settled
    task automatic count_chk(input int exp);
        #1;
        chk(ticks, exp);
        @(posedge pclk);
    endtask

    // Three rising edges of the comparator or of the count pin
    task automatic pulse_src(input logic cmp);
        repeat (3) begin
            if (cmp) pos_lv <= 8'hC0;
            else ext_drv <= 1'b1;
            cyc(8);
            if (cmp) pos_lv <= 8'h40;
            else ext_drv <= 1'b0;
            cyc(8);
        end
    endtask

    // Comparator change during sleep, then count wake pulses
    task automatic wake_try(input int exp);
        wakes <= 0;
        sleep_mode <= 1'b1;
        pos_lv <= 8'hC0;
        cyc(10);
        chk(compare_power_on, 1'b1);
        sleep_mode <= 1'b0;
        pos_lv <= 8'h40;
        cyc(10);
        #1;
        chk(wakes, exp);
        @(posedge pclk);
    endtask

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        logic [7:0] p;
        logic [7:0] q;
        // X to 0 gives the asynchronous reset an edge at time zero
        presetn <= 1'b0;
        void'($urandom(32'h2054f49a));
        cyc(10);
        chk({compare_power_on, neg_input_select, pos_input_select}, 3'h3);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h0C, 8'h00);
        rd(8'h20, 8'h0F);
        rd(8'h24, 8'h03);
        rd(8'h10, 8'h00);
        chk(rerr, 1'b1);
        // Result read only after the powered-up comparator has settled
        rd(8'h1C, 8'h7F);
        wr(8'h1C, 8'h79);
        cyc(2);
        chk({compare_power_on, neg_input_select, pos_input_select}, 3'h4);
        wr(8'h1C, 8'h71);
        cyc(2);
        chk({compare_power_on, neg_input_select, pos_input_select}, 3'h3);
        wr(8'h1C, 8'h7F);
        $display("test reset and steering done");
        // Random levels; written result bit must not stick
        for (int i = 0; i < 8; i++) begin
            p = 8'($urandom);
            q = 8'($urandom);
            if (p == q) p = q + 8'h01;
            pos_lv <= p;
            neg_lv <= q;
            cyc(10);
            wr(8'h1C, {~exp_res(p, q), 7'h7F});
            rd(8'h1C, {exp_res(p, q), 7'h7F});
        end
        neg_lv <= 8'h80;
        for (int i = 0; i < 4; i++) begin
            wr(8'h1C, i[0] ? 8'h1F : 8'h3F);
            pos_lv <= i[1] ? 8'hC0 : 8'h40;
            cyc(10);
            chk({pin_oe, pin_o}, {1'b1, i[1] ^ i[0]});
        end
        cyc(2);
        chk(pin_oe, 1'b1);
        wr(8'h1C, 8'h7F);
        cyc(3);
        chk(pin_oe, 1'b0);
        $display("test pin output done");
        wr(8'h24, 8'h00);
        cyc(8);
        ticks <= 0;
        cyc(10 * DIV);
        count_chk(10);
        wr(8'h24, 8'h02);
        pos_lv <= 8'h40;
        for (int i = 0; i < 5; i++) begin
            wr(8'h1C, tc_ctrl[i]);
            cyc(12);
            ticks <= 0;
            pulse_src(tc_cmp[i]);
            cyc(12);
            count_chk(tc_exp[i]);
        end
        // Falling-edge option on the count pin
        wr(8'h24, 8'h03);
        wr(8'h1C, 8'h7F);
        cyc(12);
        ticks <= 0;
        pulse_src(1'b0);
        cyc(12);
        count_chk(3);
        $display("test timer source done");
        // Disarm the read latch so the first try follows no read
        other_reset <= 1'b1;
        @(posedge pclk);
        other_reset <= 1'b0;
        wr(8'h24, 8'h03);
        wr(8'h1C, 8'h7E);
        cyc(12);
        wake_try(0);
        wr(8'h1C, 8'h7F);
        rd(8'h1C, 8'h7F);
        wake_try(0);
        wr(8'h1C, 8'h7E);
        rd(8'h1C, 8'h7E);
        wake_try(1);
        rd(8'h0C, 8'h40);
        wr(8'h0C, 8'h00);
        rd(8'h0C, 8'h00);
        pin_change_wake <= 1'b1;
        @(posedge pclk);
        pin_change_wake <= 1'b0;
        rd(8'h0C, 8'h80);
        other_reset <= 1'b1;
        reset_cause_wake <= 1'b1;
        cyc(2);
        chk(compare_power_on, 1'b0);
        other_reset <= 1'b0;
        reset_cause_wake <= 1'b0;
        @(posedge pclk);
        rd(8'h0C, 8'h80);
        other_reset <= 1'b1;
        cyc(2);
        other_reset <= 1'b0;
        cyc(12);
        rd(8'h0C, 8'h00);
        rd(8'h1C, 8'h7E);
        $display("test wake and resets done");
        wrap_up();
    end
endmodule // test_ccl_comparator_control
